/* sim/tcu_asserts.sv */
// port assertions for the timer compare unit
`timescale 1ns/1ps
module tcu_asserts #(parameter WIDTH = 16) (
  input wire SYS_CLK_IN, NRST_IN, TIMER_TICK_IN, TIMER_LOW_WE_IN, TIMER_HIGH_WE_IN,
  input wire ADC_ENABLE_IN, PORT_DATA_IN,
  input wire [3:0] COMPARE_MODE_FIELD_OUT,
  input wire [WIDTH-1:0] COMPARE_VALUE_PAIR_OUT, TIMER_ONE_COUNT_OUT,
  input wire TIMER_OVERFLOW_FLAG_OUT, COMPARE_FLAG_OUT, SPECIAL_TRIGGER_OUT,
  input wire ADC_GO_OUT, COMPARE_LATCH_OUT, COMPARE_OUTPUT_PIN_OUT
);
  wire hit = TIMER_ONE_COUNT_OUT == COMPARE_VALUE_PAIR_OUT;
  wire [3:0] md = COMPARE_MODE_FIELD_OUT;
  wire pm = md inside {4'h2, 4'h8, 4'h9};
  wire tk = TIMER_TICK_IN & ~TIMER_LOW_WE_IN & ~TIMER_HIGH_WE_IN;
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (!NRST_IN);
  sequence s_rise; $rose(hit) && (pm || md == 4'hA || md == 4'hB); endsequence
  a_trigger_match: assert property (SPECIAL_TRIGGER_OUT == (hit && md == 4'hB))
    else $error("trigger mismatch");
  a_flag_set: assert property (s_rise |=> COMPARE_FLAG_OUT)
    else $error("flag not set");
  a_set_clear: assert property (s_rise ##0 md[3:1] == 3'b100 |=> COMPARE_LATCH_OUT ^ $past(md[0]))
    else $error("set or clear wrong");
  a_toggle_latch: assert property (s_rise ##0 md == 4'h2 |=> $changed(COMPARE_LATCH_OUT))
    else $error("no toggle");
  a_pin_route: assert property (
    COMPARE_OUTPUT_PIN_OUT == (pm ? COMPARE_LATCH_OUT : PORT_DATA_IN)) else $error("pin route");
  a_period_reset: assert property (tk && SPECIAL_TRIGGER_OUT |=> TIMER_ONE_COUNT_OUT == 0
    && $stable(TIMER_OVERFLOW_FLAG_OUT)) else $error("no period reset");
  a_count_step: assert property (tk && !SPECIAL_TRIGGER_OUT |=>
    TIMER_ONE_COUNT_OUT == $past(TIMER_ONE_COUNT_OUT) + 1'b1) else $error("count step");
  a_adc_start: assert property (s_rise ##0 (md == 4'hB && ADC_ENABLE_IN) |=> ADC_GO_OUT)
    else $error("no conversion start");
endmodule
bind timer_compare_unit tcu_asserts #(.WIDTH(WIDTH)) i_tcu_asserts (.*);

/* sim/timer_adc_side.sv */
// far side: timer clock ticks and converter completion
`timescale 1ns/1ps
module timer_adc_side #(parameter LAT = 4'h8) (
  input wire clk_in,
  input wire run_in,
  input wire go_in,
  output wire tick_out,
  output reg done_out = 1'b0
);
  reg ph_ff = 1'b0;
  reg [3:0] cnt_ff = 4'h0;
  assign tick_out = run_in & ph_ff;
  always @(negedge clk_in) begin
    ph_ff <= ~ph_ff;
    cnt_ff <= go_in ? cnt_ff + 4'h1 : 4'h0;
    done_out <= go_in && cnt_ff == LAT;
  end
endmodule

/* sim/timer_compare_unit_tb.sv */
// self-checking bench for the timer compare unit
`timescale 1ns/1ps
module timer_compare_unit_tb;
  reg clk = 1'b0, nrst = 1'b0, adc = 1'b0, port = 1'b1, run = 1'b0;
  reg [7:0] wd = 8'h00;
  reg [6:0] we = 7'h00;
  wire tick, done, ovf, flag, trig, go, lat, pin, oe;
  wire [3:0] mode;
  wire [15:0] val, cnt;
  int fail_count = 0;
  int checks_done = 0;
  logic [3:0] md [0:5] = '{4'h2, 4'h9, 4'hA, 4'hB, 4'h2, 4'h8};
  logic [5:0] lx = 6'b110001;
  always #5 clk = ~clk;
  timer_compare_unit i_timer_compare_unit (.SYS_CLK_IN(clk), .NRST_IN(nrst),
    .CONTROL_WDATA_IN(wd), .CONTROL_WE_IN(we[0]), .VALUE_WDATA_IN(wd),
    .VALUE_LOW_WE_IN(we[1]), .VALUE_HIGH_WE_IN(we[2]), .TIMER_TICK_IN(tick),
    .TIMER_WDATA_IN(wd), .TIMER_LOW_WE_IN(we[3]), .TIMER_HIGH_WE_IN(we[4]),
    .TIMER_OVF_CLEAR_IN(we[6]), .COMPARE_FLAG_CLEAR_IN(we[5]), .ADC_ENABLE_IN(adc),
    .ADC_DONE_IN(done), .PORT_DATA_IN(port), .PIN_DIRECTION_BIT_IN(1'b0),
    .COMPARE_MODE_FIELD_OUT(mode), .COMPARE_VALUE_PAIR_OUT(val), .TIMER_ONE_COUNT_OUT(cnt),
    .TIMER_OVERFLOW_FLAG_OUT(ovf), .COMPARE_FLAG_OUT(flag), .SPECIAL_TRIGGER_OUT(trig),
    .ADC_GO_OUT(go), .COMPARE_LATCH_OUT(lat), .COMPARE_OUTPUT_PIN_OUT(pin),
    .COMPARE_OUTPUT_PIN_OE_OUT(oe));
  timer_adc_side i_timer_adc_side (.clk_in(clk), .run_in(run), .go_in(go), .tick_out(tick),
    .done_out(done));
  task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, s);
      fail_count++;
    end
  endtask
  task wr(input int k, input logic [7:0] d);
    @(negedge clk);
    wd = d;
    we = 7'h01 << k;
    @(negedge clk);
    we = 7'h00;
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    chk("reset state", {mode, flag, lat, go, ovf, trig, pin, oe, cnt[3:0]}, 15'h0030);
    $display("reset test done");
    wr(1, 8'h03);
    wr(2, 8'h01);
    chk("value pair", val, 16'h0103);
    for (int i = 0; i < 6; i++) begin
      wr(3, 8'h01);
      wr(4, 8'h01);
      wr(0, {4'h0, md[i]});
      wr(5, 8'h00);
      run = 1'b1;
      for (int n = 0; n < 20 && flag !== 1'b1; n++)
        @(negedge clk);
      run = 1'b0;
      chk("flag", flag, 1'b1);
      chk("latch", lat, lx[i]);
      chk("pin", pin, md[i] > 4'h9 ? port : lx[i]);
      $display("row %0d done", i);
    end
    wr(0, 8'h00);
    chk("cleared latch", lat, 1'b0);
    wr(3, 8'h02);
    wr(0, 8'h0B);
    wr(3, 8'h03);
    chk("trigger", trig, 1'b1);
    wr(1, 8'h04);
    chk("trigger gone", trig, 1'b0);
    chk("adc idle", go, 1'b0);
    adc = 1'b1;
    run = 1'b1;
    repeat (2) @(negedge clk);
    run = 1'b0;
    chk("count kept", cnt, 16'h0104);
    @(negedge clk);
    run = 1'b1;
    repeat (2) @(negedge clk);
    run = 1'b0;
    chk("period reset", cnt, 16'h0000);
    chk("overflow", ovf, 1'b0);
    chk("adc start", go, 1'b1);
    $display("special trigger test done");
    // plain rollover does raise the overflow flag, unlike the event reset
    wr(0, 8'h00);
    wr(3, 8'hFF);
    wr(4, 8'hFF);
    run = 1'b1;
    repeat (2) @(negedge clk);
    run = 1'b0;
    chk("rollover count", cnt, 16'h0000);
    chk("rollover flag", ovf, 1'b1);
    wr(6, 8'h00);
    chk("overflow cleared", ovf, 1'b0);
    $display("overflow test done");
    // second reset in mid-run
    wr(3, 8'h07);
    nrst = 1'b0;
    @(negedge clk);
    nrst = 1'b1;
    chk("mid reset count", cnt, 16'h0000);
    chk("mid reset flags", {flag, lat, go, ovf, mode}, 8'h00);
    chk("mid reset value", val, 16'h0000);
    $display("mid-run reset test done");
    close_out;
  end
  initial begin
    #20000;
    fail_count++;
    close_out;
  end
endmodule

/* src/timer_compare_defines.vh */
// constants for the timer compare unit
`ifndef TIMER_COMPARE_DEFINES_VH
`define TIMER_COMPARE_DEFINES_VH
`define TCU_WIDTH 16
`define TCU_MODE_OFF 4'h0
`define TCU_MODE_TOGGLE 4'h2
`define TCU_MODE_SET 4'h8
`define TCU_MODE_CLEAR 4'h9
`define TCU_MODE_SWINT 4'hA
`define TCU_MODE_SPECIAL 4'hB
`define TCU_COUNT_RESET 16'h0000
`define TCU_MODE_RESET 4'h0
`endif

/* src/timer_compare_unit.v */
// compare unit: value register matched against timer pair, pin and event actions
// Functional notes
// - compare 16-bit value against timer pair continuously; equality is a match.
// - mode field picks toggle, set, clear, special trigger or interrupt-only action.
// - every active mode raises the compare interrupt flag on a match.
// - mode 1010 raises interrupt only; pin stays under port control.
// - mode 1011 issues special trigger; pin stays under port control.
// - special trigger clears both timer bytes without setting overflow flag.
// - special trigger starts a conversion only when converter is enabled.
// - special trigger output asserts combinationally in the match cycle.
// - timer reset from trigger happens on the next timer tick edge.
// - if the match vanishes before that tick, no timer reset occurs.
// - clearing whole control register forces compare output latch low.
`timescale 1ns/1ps
`include "timer_compare_defines.vh"
module timer_compare_unit #(
  parameter WIDTH = `TCU_WIDTH
) (
  // clock and reset
  input wire SYS_CLK_IN,
  input wire NRST_IN,
  // control register
  input wire [7:0] CONTROL_WDATA_IN,
  input wire CONTROL_WE_IN,
  // compare value pair writes
  input wire [7:0] VALUE_WDATA_IN,
  input wire VALUE_LOW_WE_IN,
  input wire VALUE_HIGH_WE_IN,
  // timer writes and tick
  input wire TIMER_TICK_IN,
  input wire [7:0] TIMER_WDATA_IN,
  input wire TIMER_LOW_WE_IN,
  input wire TIMER_HIGH_WE_IN,
  input wire TIMER_OVF_CLEAR_IN,
  // flags and converter
  input wire COMPARE_FLAG_CLEAR_IN,
  input wire ADC_ENABLE_IN,
  input wire ADC_DONE_IN,
  // port side of the pin
  input wire PORT_DATA_IN,
  input wire PIN_DIRECTION_BIT_IN,
  // outputs
  output wire [3:0] COMPARE_MODE_FIELD_OUT,
  output wire [WIDTH-1:0] COMPARE_VALUE_PAIR_OUT,
  output wire [WIDTH-1:0] TIMER_ONE_COUNT_OUT,
  output wire TIMER_OVERFLOW_FLAG_OUT,
  output wire COMPARE_FLAG_OUT,
  output wire SPECIAL_TRIGGER_OUT,
  output wire ADC_GO_OUT,
  output wire COMPARE_LATCH_OUT,
  output wire COMPARE_OUTPUT_PIN_OUT,
  output wire COMPARE_OUTPUT_PIN_OE_OUT
);
  // ==========================================================
  // registers
  reg [7:0] control_ff;
  reg [WIDTH-1:0] value_ff;
  reg latch_ff;
  reg nxt_latch;
  reg flag_ff;
  reg match_seen_ff;
  reg adc_go_ff;
  wire [3:0] mode = control_ff[3:0];
  wire [WIDTH-1:0] count;
  wire match;
  wire pin_mode;
  wire special_mode;
  wire active_mode;
  wire match_edge;
  always @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      control_ff <= 8'h00;
      value_ff <= {WIDTH{1'b0}};
    end else begin
      if (CONTROL_WE_IN) begin
        control_ff <= CONTROL_WDATA_IN;
      end
      if (VALUE_LOW_WE_IN) begin
        value_ff[7:0] <= VALUE_WDATA_IN;
      end
      if (VALUE_HIGH_WE_IN) begin
        value_ff[WIDTH-1:8] <= VALUE_WDATA_IN[WIDTH-9:0];
      end
    end
  end
  // ==========================================================
  // match detection and mode decode
  assign match = (count == value_ff);
  assign special_mode = (mode == `TCU_MODE_SPECIAL);
  assign pin_mode = (mode == `TCU_MODE_TOGGLE) || (mode == `TCU_MODE_SET) ||
                    (mode == `TCU_MODE_CLEAR);
  assign active_mode = pin_mode || special_mode || (mode == `TCU_MODE_SWINT);
  // one event per match episode so a held match acts only once
  assign match_edge = active_mode && match && !match_seen_ff;
  // trigger is combinational on the live compare result
  assign SPECIAL_TRIGGER_OUT = special_mode && match;
  // ==========================================================
  // timer pair; reset taken on the next tick only while match still holds
  timer_count_pair #(
    .WIDTH(WIDTH)
  ) u_timer (
    .clk_in(SYS_CLK_IN),
    .nrst_in(NRST_IN),
    .tick_in(TIMER_TICK_IN),
    .special_reset_in(SPECIAL_TRIGGER_OUT),
    .load_low_in(TIMER_LOW_WE_IN),
    .load_high_in(TIMER_HIGH_WE_IN),
    .load_data_in(TIMER_WDATA_IN),
    .ovf_clear_in(TIMER_OVF_CLEAR_IN),
    .count_out(count),
    .ovf_flag_out(TIMER_OVERFLOW_FLAG_OUT)
  );
  // ==========================================================
  // compare output latch
  always @* begin
    nxt_latch = latch_ff;
    if (CONTROL_WE_IN && CONTROL_WDATA_IN == 8'h00) begin
      nxt_latch = 1'b0;
    end else if (match_edge) begin
      case (mode)
        `TCU_MODE_TOGGLE: begin
          nxt_latch = ~latch_ff;
        end
        `TCU_MODE_SET: begin
          nxt_latch = 1'b1;
        end
        `TCU_MODE_CLEAR: begin
          nxt_latch = 1'b0;
        end
        default: begin
          nxt_latch = latch_ff;
        end
      endcase
    end
  end
  // ==========================================================
  // flags and conversion start
  always @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      latch_ff <= 1'b0;
      flag_ff <= 1'b0;
      match_seen_ff <= 1'b0;
      adc_go_ff <= 1'b0;
    end else begin
      latch_ff <= nxt_latch;
      match_seen_ff <= match && active_mode;
      // set wins over clear
      flag_ff <= match_edge | (flag_ff & ~COMPARE_FLAG_CLEAR_IN);
      if (SPECIAL_TRIGGER_OUT && !match_seen_ff && ADC_ENABLE_IN) begin
        adc_go_ff <= 1'b1;
      end else if (ADC_DONE_IN || !ADC_ENABLE_IN) begin
        adc_go_ff <= 1'b0;
      end
    end
  end
  // ==========================================================
  // outputs; pin carries latch in pin modes, port data otherwise; enable is the inverted direction bit in every mode
  assign COMPARE_MODE_FIELD_OUT = mode;
  assign COMPARE_VALUE_PAIR_OUT = value_ff;
  assign TIMER_ONE_COUNT_OUT = count;
  assign COMPARE_FLAG_OUT = flag_ff;
  assign ADC_GO_OUT = adc_go_ff;
  assign COMPARE_LATCH_OUT = latch_ff;
  assign COMPARE_OUTPUT_PIN_OUT = pin_mode ? latch_ff : PORT_DATA_IN;
  assign COMPARE_OUTPUT_PIN_OE_OUT = ~PIN_DIRECTION_BIT_IN;
endmodule

/* src/timer_count_pair.v */
// 16-bit timer pair with load, tick, special-event reset and overflow flag
`timescale 1ns/1ps
`include "timer_compare_defines.vh"
module timer_count_pair #(
  parameter WIDTH = `TCU_WIDTH
) (
  // clock and reset
  input wire clk_in,
  input wire nrst_in,
  // control
  input wire tick_in,
  input wire special_reset_in,
  input wire load_low_in,
  input wire load_high_in,
  input wire [7:0] load_data_in,
  input wire ovf_clear_in,
  // state
  output wire [WIDTH-1:0] count_out,
  output wire ovf_flag_out
);
  reg [WIDTH-1:0] count_ff;
  reg [WIDTH-1:0] nxt_count;
  reg ovf_ff;
  reg nxt_ovf;
  always @* begin
    nxt_count = count_ff;
    nxt_ovf = ovf_ff & ~ovf_clear_in;
    if (load_low_in) begin
      nxt_count[7:0] = load_data_in;
    end else if (load_high_in) begin
      nxt_count[WIDTH-1:8] = load_data_in[WIDTH-9:0];
    end else if (tick_in) begin
      if (special_reset_in) begin
        // special event reset never raises the overflow flag
        nxt_count = {WIDTH{1'b0}};
      end else begin
        nxt_count = count_ff + {{(WIDTH-1){1'b0}}, 1'b1};
        if (&count_ff) begin
          nxt_ovf = 1'b1;
        end
      end
    end
  end
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      count_ff <= `TCU_COUNT_RESET;
      ovf_ff <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      ovf_ff <= nxt_ovf;
    end
  end
  assign count_out = count_ff;
  assign ovf_flag_out = ovf_ff;
endmodule
